/* common/qrc_pkg.sv */
// Register map, field layout and fixed counts of the quadrant receive control
package qrc_pkg;
    // Register offsets within one quadrant
    localparam logic [7:0] OFS_CLK_MON    = 8'h01;
    localparam logic [7:0] OFS_RX_OPTIONS = 8'h02;
    localparam logic [7:0] OFS_RX_LINE_IF = 8'h03;
    localparam logic [7:0] OFS_TX_LINE_IF = 8'h04;
    // Values after reset, and the writable bits of the transmit line interface
    localparam logic [7:0] RST_RX_OPTIONS = 8'h80;
    localparam logic [7:0] RST_RX_LINE_IF = 8'h00;
    localparam logic [7:0] RST_TX_LINE_IF = 8'h00;
    localparam logic [7:0] TX_LINE_IF_RW  = 8'hFA;
    // Clock monitor fields
    localparam int BIT_BP_RX_ACT   = 1;
    localparam int BIT_COMMON_ACT  = 2;
    localparam int BIT_BP_TX_ACT   = 3;
    localparam int BIT_REF_ACT     = 4;
    localparam int REF_CLK_QUAD    = 3;
    // Receive options fields
    localparam int BIT_RX_JITTER_ATTENUATOR_BYP    = 7;
    localparam int BIT_UNFRAMED    = 6;
    localparam int BIT_ELST_BYP    = 5;
    localparam int BIT_HOLD_LOS    = 4;
    localparam int BIT_FREQ_SEL    = 3;
    localparam int BIT_WORD_ERR    = 2;
    localparam int BIT_CNT_NFAS    = 1;
    localparam int BIT_CNT_COFA    = 0;
    // Receive line interface fields
    localparam int BIT_AUTO_FAR    = 7;
    localparam int BIT_AUTO_RED    = 6;
    localparam int BIT_AUTO_OOF    = 5;
    localparam int BIT_AUTO_AIS    = 4;
    localparam int BIT_BPV_ONLY    = 2;
    // Transmit line interface fields
    localparam int BIT_TJAT_BYP    = 7;
    localparam int BIT_TAIS_EN     = 6;
    localparam int BIT_TAUX_PAT    = 5;
    // Excessive-zero limits: a run longer than this is an error
    localparam logic [4:0] EXZ_T1_AMI  = 5'h0F;
    localparam logic [4:0] EXZ_T1_B8ZS = 5'h07;
    localparam logic [4:0] EXZ_E1      = 5'h04;
    localparam logic [7:0] AIS_BYTE    = 8'hFF;
    localparam int FAS_BITS            = 7;
endpackage : qrc_pkg

/* logic/qrc_quadrant_ctrl.sv */
// Per-quadrant receive option, clock monitor and alarm response logic
`timescale 1ns/1ps
module qrc_quadrant_ctrl
    import qrc_pkg::*;
#(
    parameter int QUAD_INDEX = 0
)(
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_nrst,
    // Microprocessor register port
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr_stb,
    input  wire logic       i_rd_stb,
    output logic      [7:0] o_rdata,
    // Monitored clocks and reference sources, asynchronous
    input  wire logic       i_bp_tx_clk,
    input  wire logic       i_common_tx_clk,
    input  wire logic       i_bp_rx_clk,
    input  wire logic       i_ref_clk,
    input  wire logic       i_rx_rec_clk,
    input  wire logic       i_rx_frame_8k,
    // Global mode and line status
    input  wire logic       i_e1_mode,
    input  wire logic       i_b8zs_mode,
    input  wire logic       i_los_source_select,
    input  wire logic       i_los_analog,
    input  wire logic       i_los_digital,
    input  wire logic       i_red_alarm,
    input  wire logic       i_oof,
    input  wire logic       i_ais_det,
    input  wire logic       i_manual_far_alarm,
    input  wire logic       i_manual_rx_ais,
    input  wire logic       i_frame_loss_trunk_en,
    // Framer events
    input  wire logic       i_fas_vld,
    input  wire logic [6:0] i_fas_err_bits,
    input  wire logic       i_nfas_vld,
    input  wire logic       i_nfas_bit2,
    input  wire logic       i_cofa_evt,
    input  wire logic       i_oof_evt,
    input  wire logic       i_bit_vld,
    input  wire logic       i_bit_zero,
    input  wire logic       i_bpv,
    input  wire logic       i_framer_fp,
    input  wire logic       i_fp_is_output,
    // Receive channel data
    input  wire logic       i_chan_vld,
    input  wire logic [7:0] i_direct_data,
    input  wire logic [7:0] i_elst_data,
    input  wire logic [7:0] i_idle_code,
    input  wire logic [7:0] i_trunk_data,
    input  wire logic [3:0] i_rx_sig,
    input  wire logic [3:0] i_trunk_sig,
    // Controls to datapath
    output logic            o_rx_jitter_att_bypass,
    output logic            o_refout_jitter_att,
    output logic            o_framer_reset,
    output logic            o_rx_elastic_bypass,
    output logic            o_tx_jitter_att_bypass,
    output logic            o_tx_ais_enable,
    output logic            o_tx_aux_pattern,
    // Derived outputs
    output logic            o_rx_reference_out,
    output logic            o_bp_rx_frame_pulse,
    output logic            o_tx_far_alarm,
    output logic            o_fe_inc,
    output logic      [3:0] o_fe_inc_count,
    output logic            o_perf_monitor_frame_evt,
    output logic            o_lcv_evt,
    output logic      [7:0] o_bp_rx_data,
    output logic      [3:0] o_bp_rx_signaling
);
    logic [7:0] rx_opt_reg;
    logic [7:0] rx_lif_reg;
    logic [7:0] tx_lif_reg;
    logic [3:0] act_reg;
    logic [3:0] clk_s1;
    logic [3:0] clk_s2;
    logic [3:0] clk_s3;
    logic [1:0] misc_s1;
    logic [1:0] misc_s2;
    logic       nfas_pend_reg;
    logic [4:0] zero_run_reg;
    logic       mon_rd;
    logic [3:0] clk_rise;
    logic       los_sel;
    logic       ais_on;
    logic [4:0] exz_lim;

    // All checks sample on the system clock, quiet in reset
    default clocking cb_sys @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);

    function automatic logic [3:0] ones7(input logic [6:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int k = 0; k < FAS_BITS; k++)
            n = n + {3'h0, v[k]};
        return n;
    endfunction : ones7

    assign mon_rd   = i_rd_stb && (i_addr == OFS_CLK_MON);
    assign clk_rise = clk_s2 & ~clk_s3;
    assign los_sel  = i_los_source_select ? i_los_digital
                                          : i_los_analog;
    assign ais_on   = (rx_lif_reg[BIT_AUTO_AIS] && los_sel) || i_manual_rx_ais;
    assign exz_lim  = i_e1_mode ? EXZ_E1
                    : (i_b8zs_mode ? EXZ_T1_B8ZS : EXZ_T1_AMI);

    // Pin clocks pass two flops before edge detection
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            clk_s1  <= 4'h0;
            clk_s2  <= 4'h0;
            clk_s3  <= 4'h0;
            misc_s1 <= 2'h0;
            misc_s2 <= 2'h0;
        end
        else
        begin
            clk_s1  <= {i_ref_clk, i_bp_tx_clk, i_common_tx_clk, i_bp_rx_clk};
            clk_s2  <= clk_s1;
            clk_s3  <= clk_s2;
            misc_s1 <= {i_rx_frame_8k, i_rx_rec_clk};
            misc_s2 <= misc_s1;
        end
    end

    // Sticky activity; a rise in the reading cycle survives the clear
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            act_reg <= 4'h0;
        else
        begin
            act_reg <= (mon_rd ? 4'h0 : act_reg) | clk_rise;
            if (QUAD_INDEX != REF_CLK_QUAD)
                act_reg[3] <= 1'b0;
        end
    end

    // Register writes; reserved bits are stored as written, except in the transmit line interface, where TX_LINE_IF_RW masks them
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rx_opt_reg <= RST_RX_OPTIONS;
            rx_lif_reg <= RST_RX_LINE_IF;
            tx_lif_reg <= RST_TX_LINE_IF;
        end
        else if (i_wr_stb)
        begin
            if (i_addr == OFS_RX_OPTIONS)
                rx_opt_reg <= i_wdata;
            if (i_addr == OFS_RX_LINE_IF)
                rx_lif_reg <= i_wdata;
            if (i_addr == OFS_TX_LINE_IF)
                tx_lif_reg <= i_wdata & TX_LINE_IF_RW;
        end
    end

    // Read data lands one cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            o_rdata <= 8'h00;
        else if (i_rd_stb)
        begin
            unique case (i_addr)
                OFS_CLK_MON:    o_rdata <= {3'h0, act_reg, 1'b0};
                OFS_RX_OPTIONS: o_rdata <= rx_opt_reg;
                OFS_RX_LINE_IF: o_rdata <= rx_lif_reg;
                OFS_TX_LINE_IF: o_rdata <= tx_lif_reg;
                default:        o_rdata <= 8'h00;
            endcase
        end
    end

    // Static controls; the software keeps bypass legal with clock modes
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_rx_jitter_att_bypass <= 1'b1;
            o_refout_jitter_att    <= 1'b0;
            o_framer_reset         <= 1'b0;
            o_rx_elastic_bypass    <= 1'b0;
            o_tx_jitter_att_bypass <= 1'b0;
            o_tx_ais_enable        <= 1'b0;
            o_tx_aux_pattern       <= 1'b0;
        end
        else
        begin
            o_rx_jitter_att_bypass <= rx_opt_reg[BIT_RX_JITTER_ATTENUATOR_BYP];
            o_refout_jitter_att    <= !rx_opt_reg[BIT_RX_JITTER_ATTENUATOR_BYP];
            o_framer_reset         <= rx_opt_reg[BIT_UNFRAMED];
            o_rx_elastic_bypass    <= rx_opt_reg[BIT_ELST_BYP];
            o_tx_jitter_att_bypass <= tx_lif_reg[BIT_TJAT_BYP];
            o_tx_ais_enable        <= tx_lif_reg[BIT_TAIS_EN];
            o_tx_aux_pattern       <= tx_lif_reg[BIT_TAUX_PAT];
        end
    end

    // Reference output source and frame pulse gating
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_rx_reference_out  <= 1'b0;
            o_bp_rx_frame_pulse <= 1'b0;
        end
        else
        begin
            if (los_sel)
                o_rx_reference_out <= rx_opt_reg[BIT_HOLD_LOS]
                                      ? 1'b1 : clk_s2[3];
            else
                o_rx_reference_out <= rx_opt_reg[BIT_FREQ_SEL]
                                      ? misc_s2[1] : misc_s2[0];
            o_bp_rx_frame_pulse <= (rx_opt_reg[BIT_UNFRAMED] && i_fp_is_output)
                                 ? 1'b0 : i_framer_fp;
        end
    end

    // Far-end alarm and performance event selection
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_tx_far_alarm   <= 1'b0;
            o_perf_monitor_frame_evt <= 1'b0;
        end
        else
        begin
            if (i_e1_mode)
                o_tx_far_alarm <= (rx_lif_reg[BIT_AUTO_FAR]
                                   && (i_oof || i_ais_det))
                                  || i_manual_far_alarm;
            else
                o_tx_far_alarm <= (rx_lif_reg[BIT_AUTO_FAR] && i_red_alarm)
                                  || i_manual_far_alarm;
            o_perf_monitor_frame_evt <= (!i_e1_mode && rx_opt_reg[BIT_CNT_COFA])
                                ? i_cofa_evt : i_oof_evt;
        end
    end

    // E1 framing error counting; framers held in reset count nothing
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_fe_inc       <= 1'b0;
            o_fe_inc_count <= 4'h0;
            nfas_pend_reg  <= 1'b0;
        end
        else
        begin
            o_fe_inc       <= 1'b0;
            o_fe_inc_count <= 4'h0;
            if (i_e1_mode && !rx_opt_reg[BIT_UNFRAMED] && i_fas_vld)
            begin
                if (rx_opt_reg[BIT_WORD_ERR] && rx_opt_reg[BIT_CNT_NFAS])
                    nfas_pend_reg <= |i_fas_err_bits;
                else if (rx_opt_reg[BIT_WORD_ERR])
                begin
                    o_fe_inc       <= |i_fas_err_bits;
                    o_fe_inc_count <= {3'h0, |i_fas_err_bits};
                end
                else
                begin
                    o_fe_inc       <= |i_fas_err_bits;
                    o_fe_inc_count <= ones7(i_fas_err_bits);
                end
            end
            else if (i_e1_mode && !rx_opt_reg[BIT_UNFRAMED] && i_nfas_vld
                     && rx_opt_reg[BIT_CNT_NFAS])
            begin
                if (rx_opt_reg[BIT_WORD_ERR])
                begin
                    o_fe_inc       <= nfas_pend_reg || !i_nfas_bit2;
                    o_fe_inc_count <= {3'h0, nfas_pend_reg || !i_nfas_bit2};
                    nfas_pend_reg  <= 1'b0;
                end
                else
                begin
                    o_fe_inc       <= !i_nfas_bit2;
                    o_fe_inc_count <= {3'h0, !i_nfas_bit2};
                end
            end
        end
    end

    // Line code violations; excessive zeros flagged once per run
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            zero_run_reg <= 5'h00;
            o_lcv_evt    <= 1'b0;
        end
        else
        begin
            o_lcv_evt <= i_bpv;
            if (i_bit_vld)
            begin
                if (!i_bit_zero)
                    zero_run_reg <= 5'h00;
                else if (zero_run_reg <= exz_lim)
                    zero_run_reg <= zero_run_reg + 5'h01;
                if (i_bit_zero && zero_run_reg == exz_lim
                    && !rx_lif_reg[BIT_BPV_ONLY])
                    o_lcv_evt <= 1'b1;
            end
        end
    end

    // Channel data: AIS over trunk conditioning over trouble code
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_bp_rx_data      <= 8'h00;
            o_bp_rx_signaling <= 4'h0;
        end
        else if (i_chan_vld)
        begin
            if (ais_on)
                o_bp_rx_data <= AIS_BYTE;
            else if ((rx_lif_reg[BIT_AUTO_RED] && i_red_alarm)
                     || (rx_lif_reg[BIT_AUTO_OOF] && i_oof))
                o_bp_rx_data <= i_trunk_data;
            else if (rx_opt_reg[BIT_ELST_BYP])
                o_bp_rx_data <= i_direct_data;
            else if (i_frame_loss_trunk_en && i_oof)
                o_bp_rx_data <= i_idle_code;
            else
                o_bp_rx_data <= i_elst_data;
            // Frozen at whatever was sent last, trunk value included
            if (ais_on)
                o_bp_rx_signaling <= o_bp_rx_signaling;
            else if (rx_lif_reg[BIT_AUTO_RED] && i_red_alarm)
                o_bp_rx_signaling <= i_trunk_sig;
            else
                o_bp_rx_signaling <= i_rx_sig;
        end
    end

    a_flag_set_wins: assert property (
        (mon_rd && clk_rise[0]) |=> act_reg[0])
        else $error("activity lost on clearing read");
    a_read_clears: assert property (
        (mon_rd && clk_rise[1:0] == 2'b00) |=> act_reg[1:0] == 2'b00)
        else $error("activity not cleared by read");
    a_ref_flag_quad: assert property (
        (QUAD_INDEX != REF_CLK_QUAD) |-> !act_reg[3])
        else $error("reference flag set in wrong quadrant");
    a_unframed_fp_low: assert property (
        (rx_opt_reg[BIT_UNFRAMED] && i_fp_is_output)
        |=> !o_bp_rx_frame_pulse)
        else $error("frame pulse not held low");
    a_refout_hold: assert property (
        (los_sel && rx_opt_reg[BIT_HOLD_LOS]) [*2] |=> o_rx_reference_out)
        else $error("reference output not held high");
    a_t1_far_alarm: assert property (
        (!i_e1_mode && rx_lif_reg[BIT_AUTO_FAR] && i_red_alarm)
        |=> o_tx_far_alarm)
        else $error("yellow missing on red alarm");
    a_ais_data_ones: assert property (
        (i_chan_vld && rx_lif_reg[BIT_AUTO_AIS] && los_sel)
        |=> o_bp_rx_data == AIS_BYTE && $stable(o_bp_rx_signaling))
        else $error("AIS not inserted on loss");
    a_perf_monitor_cofa_sel: assert property (
        (!i_e1_mode && rx_opt_reg[BIT_CNT_COFA] && !i_cofa_evt)
        |=> !o_perf_monitor_frame_evt)
        else $error("wrong frame event counted");
    a_bpv_counts: assert property (
        i_bpv |=> o_lcv_evt)
        else $error("violation not counted");
endmodule : qrc_quadrant_ctrl

/* sim/qrc_line_partner.sv */
// Far-side clock sources feeding the monitored and reference clock pins
`timescale 1ns/1ps
module qrc_line_partner (
    // One enable per source
    input  wire logic [5:0] i_clk_en,
    // Generated clocks
    output logic      [5:0] o_far_clk
);
    for (genvar k = 0; k < 6; k++)
    begin : g_src
        logic clk_q;
        assign o_far_clk[k] = clk_q;
        // Half periods off the 10 ns grid keep the sources unrelated to the system clock
        initial
        begin
            clk_q = 1'b0;
            forever
            begin
                #(101 + 37 * k);
                // A stopped source rests low, as a failed clock would
                clk_q = i_clk_en[k] ? ~clk_q : 1'b0;
            end
        end
    end
endmodule : qrc_line_partner

/* sim/qrc_quadrant_ctrl_bench.sv */
// Self-checking bench for the quadrant receive control block
`timescale 1ns/1ps
module qrc_quadrant_ctrl_bench;
    import qrc_pkg::*;
    localparam logic [6:0] EV_FAS = 7'h01;
    localparam logic [6:0] EV_NFAS = 7'h02;
    localparam logic [6:0] EV_BIT = 7'h10;
    localparam logic [6:0] EV_BPV = 7'h20;
    localparam logic [6:0] EV_CHAN = 7'h40;
    localparam logic [7:0] MON_EXP [4] = '{8'h08, 8'h04, 8'h02, 8'h10};
    // e1, auto, red, oof, ais, manual, expected alarm
    localparam logic [6:0] FAR_TAB [9] = '{7'h69, 7'h65, 7'h70, 7'h31,
        7'h28, 7'h10, 7'h03, 7'h48, 7'h43};
    // e1, count select, oof event, frame change event, expected
    localparam logic [4:0] PM_TAB [6] = '{5'h0B, 5'h0C, 5'h05, 5'h02,
        5'h1D, 5'h1A};
    localparam logic [1:0] LCV_MODE [3] = '{2'b10, 2'b00, 2'b01};
    localparam logic [4:0] LCV_LIM [3] = '{EXZ_E1, EXZ_T1_AMI, EXZ_T1_B8ZS};
    // line cfg, {bypass,red,oof,los}, trunk en, rx sig, exp sig, exp data
    localparam logic [31:0] DP_TAB [8] = '{32'h0000_5522, 32'h0021_5533,
        32'h2021_5544, 32'h4040_5A44, 32'h0080_5511, 32'h00A1_5511,
        32'h1010_65FF, 32'h0010_6622};
    logic       i_clk_sys, i_nrst, i_wr_stb, i_rd_stb;
    logic [7:0] i_addr, i_wdata, o_rdata;
    logic       i_e1_mode, i_b8zs_mode, i_los_source_select, i_los_analog;
    logic       i_los_digital, i_red_alarm, i_oof, i_ais_det;
    logic       i_manual_far_alarm, i_manual_rx_ais, i_frame_loss_trunk_en;
    logic       i_fas_vld, i_nfas_vld, i_nfas_bit2, i_cofa_evt, i_oof_evt;
    logic       i_bit_vld, i_bit_zero, i_bpv, i_framer_fp, i_fp_is_output;
    logic       i_chan_vld;
    logic [6:0] i_fas_err_bits;
    logic [7:0] i_direct_data, i_elst_data, i_idle_code, i_trunk_data;
    logic [3:0] i_rx_sig, i_trunk_sig, o_fe_inc_count, o_bp_rx_signaling;
    logic [7:0] o_bp_rx_data;
    logic       o_rx_jitter_att_bypass, o_refout_jitter_att, o_framer_reset;
    logic       o_rx_elastic_bypass, o_tx_jitter_att_bypass, o_tx_ais_enable;
    logic       o_tx_aux_pattern, o_rx_reference_out, o_bp_rx_frame_pulse;
    logic       o_tx_far_alarm, o_fe_inc, o_perf_monitor_frame_evt, o_lcv_evt;
    logic [5:0] clk_en, far_clk;
    int         mismatches, total_checks, n;

    qrc_line_partner partner (.i_clk_en(clk_en), .o_far_clk(far_clk));

    qrc_quadrant_ctrl #(.QUAD_INDEX(3)) dut (
        .i_clk_sys, .i_nrst, .i_addr, .i_wdata, .i_wr_stb, .i_rd_stb,
        .o_rdata, .i_bp_tx_clk(far_clk[0]), .i_common_tx_clk(far_clk[1]),
        .i_bp_rx_clk(far_clk[2]), .i_ref_clk(far_clk[3]),
        .i_rx_rec_clk(far_clk[4]), .i_rx_frame_8k(far_clk[5]),
        .i_e1_mode, .i_b8zs_mode, .i_los_source_select, .i_los_analog,
        .i_los_digital, .i_red_alarm, .i_oof, .i_ais_det,
        .i_manual_far_alarm, .i_manual_rx_ais, .i_frame_loss_trunk_en,
        .i_fas_vld, .i_fas_err_bits, .i_nfas_vld, .i_nfas_bit2, .i_cofa_evt,
        .i_oof_evt, .i_bit_vld, .i_bit_zero, .i_bpv, .i_framer_fp,
        .i_fp_is_output, .i_chan_vld, .i_direct_data, .i_elst_data,
        .i_idle_code, .i_trunk_data, .i_rx_sig, .i_trunk_sig,
        .o_rx_jitter_att_bypass, .o_refout_jitter_att, .o_framer_reset,
        .o_rx_elastic_bypass, .o_tx_jitter_att_bypass, .o_tx_ais_enable,
        .o_tx_aux_pattern, .o_rx_reference_out, .o_bp_rx_frame_pulse,
        .o_tx_far_alarm, .o_fe_inc, .o_fe_inc_count, .o_perf_monitor_frame_evt,
        .o_lcv_evt, .o_bp_rx_data, .o_bp_rx_signaling);

    task automatic cyc(input int k);
        repeat (k) @(posedge i_clk_sys);
    endtask : cyc

    task automatic settle(input int k);
        repeat (k) @(posedge i_clk_sys);
        #1;
    endtask : settle

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr_stb <= 1'b1;
        @(posedge i_clk_sys);
        i_wr_stb <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd_stb <= 1'b1;
        @(posedge i_clk_sys);
        i_rd_stb <= 1'b0;
        #1;
        chk(o_rdata, exp);
    endtask : rd

    // One-cycle event pulses; outputs looked at in the following cycle
    task automatic ev(input logic [6:0] s);
        @(posedge i_clk_sys);
        {i_chan_vld, i_bpv, i_bit_vld, i_oof_evt, i_cofa_evt, i_nfas_vld,
            i_fas_vld} <= s;
        @(posedge i_clk_sys);
        {i_chan_vld, i_bpv, i_bit_vld, i_oof_evt, i_cofa_evt, i_nfas_vld,
            i_fas_vld} <= '0;
        #1;
    endtask : ev

    task automatic count_tog(output int c);
        logic p;
        c = 0;
        p = o_rx_reference_out;
        repeat (60)
        begin
            @(posedge i_clk_sys);
            #1;
            if (o_rx_reference_out !== p)
                c++;
            p = o_rx_reference_out;
        end
    endtask : count_tog

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    initial
    begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    // Bounded run time in case a sequence stalls
    initial
    begin
        #(400_000);
        mismatches++;
        give_verdict();
    end

    initial
    begin
        {i_wr_stb, i_rd_stb, i_e1_mode, i_b8zs_mode, i_los_source_select,
            i_los_analog, i_los_digital, i_red_alarm, i_oof, i_ais_det,
            i_manual_far_alarm, i_manual_rx_ais, i_frame_loss_trunk_en,
            i_fas_vld, i_nfas_vld, i_nfas_bit2, i_cofa_evt, i_oof_evt,
            i_bit_vld, i_bit_zero, i_bpv, i_chan_vld} = '0;
        {i_framer_fp, i_fp_is_output} = 2'b11;
        {i_addr, i_wdata, i_fas_err_bits} = '0;
        {i_direct_data, i_elst_data} = 16'h1122;
        {i_idle_code, i_trunk_data} = 16'h3344;
        {i_rx_sig, i_trunk_sig} = 8'h5A;
        clk_en = '0;
        i_nrst = 1'b0;
        cyc(20);
        #1;
        chk(o_rdata, 8'h00);
        chk({o_rx_jitter_att_bypass, o_refout_jitter_att, o_framer_reset,
            o_rx_elastic_bypass, o_bp_rx_frame_pulse}, 8'h10);
        cyc(1);
        i_nrst <= 1'b1;
        rd(OFS_RX_OPTIONS, RST_RX_OPTIONS);
        rd(OFS_RX_LINE_IF, RST_RX_LINE_IF);
        rd(OFS_TX_LINE_IF, RST_TX_LINE_IF);
        rd(OFS_CLK_MON, 8'h00);
        wr(8'h05, 8'h5A);
        rd(8'h05, 8'h00);
        wr(OFS_TX_LINE_IF, 8'hE0);
        rd(OFS_TX_LINE_IF, 8'hE0);
        chk({o_tx_jitter_att_bypass, o_tx_ais_enable, o_tx_aux_pattern}, 7);
        wr(OFS_RX_OPTIONS, 8'h60);
        rd(OFS_RX_OPTIONS, 8'h60);
        chk({o_rx_jitter_att_bypass, o_refout_jitter_att, o_framer_reset,
            o_rx_elastic_bypass, o_bp_rx_frame_pulse},
            8'h0E);
        wr(OFS_RX_OPTIONS, 8'h80);
        settle(2);
        chk({o_rx_jitter_att_bypass, o_refout_jitter_att, o_framer_reset,
            o_rx_elastic_bypass, o_bp_rx_frame_pulse}, 8'h11);
        for (int k = 0; k < 4; k++)
        begin
            clk_en = 6'(1 << k);
            cyc(40);
            clk_en = '0;
            cyc(10);
            rd(OFS_CLK_MON, MON_EXP[k]);
            rd(OFS_CLK_MON, 8'h00);
        end
        cyc(1);
        i_los_analog <= 1'b1;
        wr(OFS_RX_OPTIONS, 8'h90);
        settle(4);
        chk(o_rx_reference_out, 1);
        clk_en = 6'h18;
        cyc(1);
        i_los_source_select <= 1'b1;
        count_tog(n);
        chk(n > 0, 1);
        wr(OFS_RX_OPTIONS, 8'h88);
        settle(4);
        count_tog(n);
        chk(n == 0, 1);
        wr(OFS_RX_OPTIONS, 8'h80);
        i_los_source_select <= 1'b0;
        count_tog(n);
        chk(n > 0, 1);
        clk_en = '0;
        cyc(1);
        i_e1_mode <= 1'b1;
        i_fas_err_bits <= 7'h53;
        ev(EV_FAS);
        chk({o_fe_inc, o_fe_inc_count}, 8'h14);
        wr(OFS_RX_OPTIONS, 8'h84);
        ev(EV_FAS);
        chk({o_fe_inc, o_fe_inc_count}, 8'h11);
        wr(OFS_RX_OPTIONS, 8'h82);
        ev(EV_NFAS);
        chk({o_fe_inc, o_fe_inc_count}, 8'h11);
        wr(OFS_RX_OPTIONS, 8'h86);
        i_nfas_bit2 <= 1'b1;
        ev(EV_FAS);
        chk(o_fe_inc, 0);
        ev(EV_NFAS);
        chk({o_fe_inc, o_fe_inc_count}, 8'h11);
        for (int k = 0; k < 9; k++)
        begin
            wr(OFS_RX_LINE_IF, {FAR_TAB[k][5], 7'h00});
            {i_e1_mode, i_red_alarm, i_oof, i_ais_det, i_manual_far_alarm}
                <= {FAR_TAB[k][6], FAR_TAB[k][4:1]};
            settle(3);
            chk(o_tx_far_alarm, FAR_TAB[k][0]);
        end
        for (int k = 0; k < 6; k++)
        begin
            wr(OFS_RX_OPTIONS, {7'h40, PM_TAB[k][3]});
            i_e1_mode <= PM_TAB[k][4];
            ev({3'b000, PM_TAB[k][2:1], 2'b00});
            chk(o_perf_monitor_frame_evt, PM_TAB[k][0]);
        end
        wr(OFS_RX_LINE_IF, 8'h00);
        for (int k = 0; k < 3; k++)
        begin
            cyc(1);
            {i_e1_mode, i_b8zs_mode} <= LCV_MODE[k];
            i_bit_zero <= 1'b0;
            ev(EV_BIT);
            cyc(1);
            i_bit_zero <= 1'b1;
            for (int z = 1; z <= LCV_LIM[k] + 2; z++)
            begin
                ev(EV_BIT);
                chk(o_lcv_evt, z == LCV_LIM[k] + 1);
            end
        end
        wr(OFS_RX_LINE_IF, 8'h04);
        cyc(1);
        i_bit_zero <= 1'b0;
        ev(EV_BIT);
        cyc(1);
        i_bit_zero <= 1'b1;
        repeat (9)
        begin
            ev(EV_BIT);
            chk(o_lcv_evt, 0);
        end
        ev(EV_BPV);
        chk(o_lcv_evt, 1);
        for (int k = 0; k < 8; k++)
        begin
            wr(OFS_RX_LINE_IF, DP_TAB[k][31:24]);
            wr(OFS_RX_OPTIONS, {2'b10, DP_TAB[k][23], 5'h00});
            {i_red_alarm, i_oof, i_los_analog} <= DP_TAB[k][22:20];
            {i_ais_det, i_manual_far_alarm} <= 2'b00;
            i_frame_loss_trunk_en <= DP_TAB[k][16];
            i_rx_sig <= DP_TAB[k][15:12];
            cyc(2);
            ev(EV_CHAN);
            chk(o_bp_rx_data, DP_TAB[k][7:0]);
            chk(o_bp_rx_signaling, DP_TAB[k][11:8]);
        end
        cyc(1);
        i_manual_rx_ais <= 1'b1;
        ev(EV_CHAN);
        chk(o_bp_rx_data, AIS_BYTE);
        give_verdict();
    end
endmodule : qrc_quadrant_ctrl_bench
